/* File: sat_timer.sv */
// Split auto-reload timer top: special function registers and counters
`timescale 1ns/1ps
`include "sat_regs.svh"
module sat_timer
    import sat_pkg::*;
(
    // Clock and reset
    input  wire logic      clock,
    input  wire logic      resetn,
    input  wire logic      clk_en,
    // Register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic      sfr_wr,
    input  wire logic      sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic [7:0]     sfr_rdata,
    // Clock selects from the clock select register
    input  wire logic      high_byte_clock_select,
    input  wire logic      low_byte_clock_select,
    // Interrupt enable from the extended irq enable register
    input  wire logic      timer_irq_enable,
    // Oscillator pins
    input  wire logic      ext_osc,
    input  wire logic      lfo_out,
    // Interrupt request
    output logic           irq
);
    sat_byte_t control_q;
    sat_byte_t reload_lo_q;
    sat_byte_t reload_hi_q;
    sat_byte_t count_lo_q;
    sat_byte_t count_hi_q;
    logic      lfo_meta_q;
    logic      lfo_sync_q;
    logic      lfo_prev_q;
    logic      div12_tick;
    logic      ext8_tick;

    sat_tick_gen #(
        .SYS_DIV (`SAT_SYS_DIV),
        .EXT_DIV (`SAT_EXT_DIV)
    ) u_ticks (
        .clock      (clock),
        .resetn     (resetn),
        .clk_en     (clk_en),
        .ext_osc    (ext_osc),
        .div12_tick (div12_tick),
        .ext8_tick  (ext8_tick)
    );

    // Control fields
    wire split_mode_enable       = control_q[`SAT_BIT_SPLIT];
    wire run_control             = control_q[`SAT_BIT_RUN];
    wire external_clock_select   = control_q[`SAT_BIT_EXT_SEL];
    wire low_overflow_irq_enable = control_q[`SAT_BIT_LOW_IRQ_EN];
    wire lfo_capture_enable      = control_q[`SAT_BIT_CAPTURE_EN];
    wire high_overflow_flag      = control_q[`SAT_BIT_HIGH_FLAG];
    wire low_overflow_flag       = control_q[`SAT_BIT_LOW_FLAG];

    // Clock source choice per byte
    wire ext_tick   = external_clock_select ? ext8_tick : div12_tick; // R7
    wire hi_tick    = high_byte_clock_select ? 1'b1 : ext_tick; // R7
    wire lo_tick_sp = low_byte_clock_select ? 1'b1 : ext_tick; // R7
    wire lo_tick    = split_mode_enable ? lo_tick_sp : hi_tick; // R16

    // Advance conditions
    wire full_adv = !split_mode_enable && run_control && hi_tick; // R1 R15
    wire lo_adv   = split_mode_enable ? lo_tick : full_adv; // R6
    wire hi_adv   = split_mode_enable ? (run_control && hi_tick) // R6 R15
                                      : (full_adv && count_lo_q == 8'hff); // R1
    wire lo_wrap  = lo_adv && (count_lo_q == 8'hff); // R10
    wire hi_wrap  = hi_adv && (count_hi_q == 8'hff); // R9

    // Capture edge on the low-frequency oscillator
    wire lfo_rise = lfo_sync_q & ~lfo_prev_q;
    wire capture  = lfo_capture_enable && timer_irq_enable && lfo_rise; // R13
    logic capture_pend_q;

    // Register write decode
    wire wr_ctrl = sfr_wr && (sfr_addr == `SAT_ADDR_CONTROL);
    wire wr_rll  = sfr_wr && (sfr_addr == `SAT_ADDR_RELOAD_LO);
    wire wr_rlh  = sfr_wr && (sfr_addr == `SAT_ADDR_RELOAD_HI);
    wire wr_cl   = sfr_wr && (sfr_addr == `SAT_ADDR_COUNT_LO);
    wire wr_ch   = sfr_wr && (sfr_addr == `SAT_ADDR_COUNT_HI);

    // Next control value: write then hardware sets win over clears
    sat_byte_t ctrl_wr;
    sat_byte_t control_d;
    assign ctrl_wr = wr_ctrl ? (sfr_wdata & `SAT_CONTROL_WMASK) // R14
                             : control_q;
    always_comb begin
        control_d = ctrl_wr;
        if (hi_wrap) begin
            control_d[`SAT_BIT_HIGH_FLAG] = 1'b1; // R2 R9 R12
        end
        if (lo_wrap) begin
            control_d[`SAT_BIT_LOW_FLAG] = 1'b1; // R10 R12
        end
    end

    // Next count values
    sat_byte_t count_lo_d;
    sat_byte_t count_hi_d;
    always_comb begin
        count_lo_d = count_lo_q;
        count_hi_d = count_hi_q;
        if (split_mode_enable) begin
            if (lo_adv) begin
                count_lo_d = lo_wrap ? reload_lo_q : 8'(count_lo_q + 8'h01); // R5
            end
            if (hi_adv) begin
                count_hi_d = hi_wrap ? reload_hi_q : 8'(count_hi_q + 8'h01); // R5
            end
        end else if (full_adv) begin
            if (hi_wrap) begin
                count_lo_d = reload_lo_q; // R2
                count_hi_d = reload_hi_q; // R2
            end else begin
                count_lo_d = 8'(count_lo_q + 8'h01); // R1
                count_hi_d = hi_adv ? 8'(count_hi_q + 8'h01) : count_hi_q; // R1
            end
        end
        // Software write wins over a count step in the same cycle
        if (wr_cl) begin
            count_lo_d = sfr_wdata;
        end
        if (wr_ch) begin
            count_hi_d = sfr_wdata;
        end
    end

    // Next reload values: capture overrides software write
    sat_byte_t reload_lo_d;
    sat_byte_t reload_hi_d;
    assign reload_lo_d = capture ? count_lo_q : (wr_rll ? sfr_wdata : reload_lo_q); // R13
    assign reload_hi_d = capture ? count_hi_q : (wr_rlh ? sfr_wdata : reload_hi_q); // R13

    // Interrupt request from flags and capture
    wire low_irq_src = low_overflow_irq_enable && low_overflow_flag; // R4 R11
    assign irq = timer_irq_enable && (high_overflow_flag || low_irq_src) // R3 R11
                 || capture_pend_q; // R13

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            control_q   <= `SAT_CONTROL_RESET;
            reload_lo_q <= `SAT_RELOAD_RESET;
            reload_hi_q <= `SAT_RELOAD_RESET;
            count_lo_q  <= `SAT_COUNT_RESET;
            count_hi_q  <= `SAT_COUNT_RESET;
        end else if (clk_en) begin
            control_q   <= control_d;
            reload_lo_q <= reload_lo_d;
            reload_hi_q <= reload_hi_d;
            count_lo_q  <= count_lo_d;
            count_hi_q  <= count_hi_d;
        end
    end

    // Oscillator synchroniser and capture request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lfo_meta_q     <= 1'b0;
            lfo_sync_q     <= 1'b0;
            lfo_prev_q     <= 1'b0;
            capture_pend_q <= 1'b0;
        end else if (clk_en) begin
            lfo_meta_q     <= lfo_out;
            lfo_sync_q     <= lfo_meta_q;
            lfo_prev_q     <= lfo_sync_q;
            capture_pend_q <= capture || (capture_pend_q && !wr_ctrl);
        end
    end

    // Read data
    sat_byte_t rd_mux;
    always_comb begin
        case (sfr_addr)
            `SAT_ADDR_CONTROL:   rd_mux = control_q;
            `SAT_ADDR_RELOAD_LO: rd_mux = reload_lo_q;
            `SAT_ADDR_RELOAD_HI: rd_mux = reload_hi_q;
            `SAT_ADDR_COUNT_LO:  rd_mux = count_lo_q;
            `SAT_ADDR_COUNT_HI:  rd_mux = count_hi_q;
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
        end else if (clk_en) begin
            sfr_rdata <= sfr_rd ? rd_mux : 8'h00;
        end
    end
endmodule : sat_timer

/* File: sat_regs.svh */
// Register addresses, field positions and reset values of the split auto-reload timer
// Operation
// R1: Split clear chains bytes into 16-bit reload counter
// R2: 16-bit wrap reloads pair, sets high flag
// R3: Timer irq enable requests on 16-bit overflow
// R4: Low irq enable adds low-byte wrap request
// R5: Split set gives two 8-bit reload counters
// R6: Split mode: run gates high byte only
// R7: Clock select: system_clock, system_clock/12 or ext/8
// R8: Ext/8 clock synchronised before counting
// R9: High flag set on high-byte wrap
// R10: Low flag set on low-byte wrap, any mode
// R11: Split irq on high, optionally low overflow
// R12: Flags cleared only by software
// R13: Capture copies count to reload on lfo rise
// R14: Control bit 1 reads zero, ignores writes
// R15: Run bit clear stops, set runs timer
// R16: 16-bit mode uses high-byte clock select
`ifndef SAT_REGS_SVH
`define SAT_REGS_SVH
`define SAT_ADDR_CONTROL    8'h91
`define SAT_ADDR_RELOAD_LO  8'h92
`define SAT_ADDR_RELOAD_HI  8'h93
`define SAT_ADDR_COUNT_LO   8'h94
`define SAT_ADDR_COUNT_HI   8'h95
`define SAT_BIT_HIGH_FLAG   7
`define SAT_BIT_LOW_FLAG    6
`define SAT_BIT_LOW_IRQ_EN  5
`define SAT_BIT_CAPTURE_EN  4
`define SAT_BIT_SPLIT       3
`define SAT_BIT_RUN         2
`define SAT_BIT_EXT_SEL     0
`define SAT_CONTROL_RESET   8'h00
`define SAT_RELOAD_RESET    8'h00
`define SAT_COUNT_RESET     8'h00
`define SAT_CONTROL_WMASK   8'hfd
`define SAT_SYS_DIV         12
`define SAT_EXT_DIV         8
`endif

/* File: sat_pkg.sv */
// Types shared by the split auto-reload timer
package sat_pkg;
    typedef logic [7:0] sat_byte_t;
    typedef enum logic [1:0] {
        SAT_SRC_SYS,
        SAT_SRC_DIV12,
        SAT_SRC_EXT8
    } sat_src_e;
endpackage : sat_pkg

/* File: sat_tick_gen.sv */
// Count tick generator: system clock /12 and synchronised external clock /8
`timescale 1ns/1ps
`include "sat_regs.svh"
module sat_tick_gen
    import sat_pkg::*;
#(
    parameter int SYS_DIV = `SAT_SYS_DIV,
    parameter int EXT_DIV = `SAT_EXT_DIV
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic clk_en,
    // External oscillator
    input  wire logic ext_osc,
    // Ticks
    output logic      div12_tick,
    output logic      ext8_tick
);
    initial begin
        if (SYS_DIV < 2 || SYS_DIV > 256 || EXT_DIV < 2 || EXT_DIV > 256) begin
            $error("sat_tick_gen: divider out of range");
        end
    end

    localparam logic [7:0] SYS_LAST = 8'(SYS_DIV - 1);
    localparam logic [7:0] EXT_LAST = 8'(EXT_DIV - 1);

    logic [7:0] sys_cnt_q;
    logic [7:0] ext_cnt_q;
    logic       ext_meta_q;
    logic       ext_sync_q;
    logic       ext_prev_q;
    wire        ext_rise = ext_sync_q & ~ext_prev_q;
    wire        sys_wrap = (sys_cnt_q == SYS_LAST);
    wire        ext_wrap = ext_rise && (ext_cnt_q == EXT_LAST);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sys_cnt_q  <= 8'h00;
            ext_cnt_q  <= 8'h00;
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
            div12_tick <= 1'b0;
            ext8_tick  <= 1'b0;
        end else if (clk_en) begin
            ext_meta_q <= ext_osc; // R8
            ext_sync_q <= ext_meta_q; // R8
            ext_prev_q <= ext_sync_q;
            sys_cnt_q  <= sys_wrap ? 8'h00 : 8'(sys_cnt_q + 8'h01);
            if (ext_rise) begin
                ext_cnt_q <= ext_wrap ? 8'h00 : 8'(ext_cnt_q + 8'h01);
            end
            div12_tick <= sys_wrap;
            ext8_tick  <= ext_wrap;
        end
    end
endmodule : sat_tick_gen

/* File: sat_timer_assertions.sv */
// Port-level checker for the split auto-reload timer
`timescale 1ns/1ps
module sat_timer_checker (
    // Clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       clk_en,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Interrupt
    input wire logic       timer_irq_enable,
    input wire logic       irq
);
    logic       rd_q;
    logic [1:0] seen_q;
    logic       cap_q;
    wire        ctl = sfr_addr == 8'h91;
    // Flags seen set by a control read, forgotten on a control write
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_q   <= 1'b0;
            seen_q <= 2'h0;
            cap_q  <= 1'b0;
        end else begin
            rd_q <= sfr_rd && clk_en && ctl;
            if (sfr_wr && ctl)
                seen_q <= 2'h0;
            else if (rd_q)
                seen_q <= seen_q | sfr_rdata[7:6];
            if (sfr_wr && clk_en && ctl)
                cap_q <= sfr_wdata[4];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_idle; clk_en && !sfr_rd |=> sfr_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero when idle");
    property p_unmapped;
        clk_en && sfr_rd && !(sfr_addr inside {[8'h91:8'h95]}) |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_bit1; rd_q |-> !sfr_rdata[1]; endproperty
    a_bit1: assert property (p_bit1) else $error("control bit 1 not zero");
    property p_wback;
        clk_en && sfr_wr && ctl ##1 clk_en && sfr_rd && ctl && !sfr_wr
        |=> (sfr_rdata & 8'h3d) == ($past(sfr_wdata, 2) & 8'h3d);
    endproperty
    a_wback: assert property (p_wback) else $error("control bits lost");
    property p_reload;
        clk_en && sfr_wr && sfr_addr == 8'h92 ##1 clk_en && sfr_rd && sfr_addr == 8'h92
        && !sfr_wr |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_reload: assert property (p_reload) else $error("reload byte lost");
    property p_sticky; rd_q |-> (sfr_rdata[7:6] & seen_q) == seen_q; endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");
    property p_rise; $rose(irq) |-> timer_irq_enable || $past(timer_irq_enable); endproperty
    a_rise: assert property (p_rise) else $error("irq without enable");
    property p_nosrc; !timer_irq_enable && !cap_q |-> !irq; endproperty
    a_nosrc: assert property (p_nosrc) else $error("irq with no source");
    c_irq: cover property (irq);
    c_high: cover property (rd_q && sfr_rdata[7]);
    c_low: cover property (rd_q && sfr_rdata[6]);
endmodule : sat_timer_checker
bind sat_timer sat_timer_checker u_chk (.clock(clock), .resetn(resetn), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable), .irq(irq));

/* File: test_split_autoreload_timer.sv */
// Self-checking bench for the split auto-reload timer
`timescale 1ns/1ps
module test_split_autoreload_timer;
    logic        clock = 0, resetn = 0, clk_en = 1, sfr_wr = 0, sfr_rd = 0, rd_q = 0;
    logic        hsel = 1, lsel = 1, tie = 1, ext_osc = 0, lfo_out = 0, irq;
    logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata, r0, r1;
    logic [15:0] e, v;
    logic [15:0] exp_q[$];
    int          num_errors = 0, comparisons = 0, seed = 32'h36a17fda;
    sat_timer uut (.clock(clock), .resetn(resetn), .clk_en(clk_en), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .high_byte_clock_select(hsel), .low_byte_clock_select(lsel),
        .timer_irq_enable(tie), .ext_osc(ext_osc), .lfo_out(lfo_out), .irq(irq));
    always #12.5 clock = ~clock;
    always #30 ext_osc = ~ext_osc;
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] x);
        comparisons++;
        if (s !== x) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask : check
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #2;
        sfr_wr = w;
        sfr_rd = r;
        sfr_addr = a;
        sfr_wdata = d;
    endtask : op
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m = 8'hff);
        exp_q.push_back({m, x});
        op(0, 1, a, 8'h00);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) op(0, 0, 8'h00, 8'h00);
    endtask : idle
    task automatic stop_test();
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // Read results land one cycle after the request
    always @(negedge clock) begin
        if (rd_q) begin
            e = exp_q.pop_front();
            check("sfr_rdata", sfr_rdata & e[15:8], e[7:0] & e[15:8]);
        end
        rd_q = sfr_rd;
    end
    initial begin
        repeat (2000) @(posedge clock);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clock);
        #2 resetn = 1;
        r0 = 8'($random(seed));
        r1 = 8'($random(seed)) & 8'h7f;
        for (int a = 8'h91; a <= 8'h96; a++) rd(8'(a), 8'h00);
        op(1, 0, 8'h91, 8'h02);
        rd(8'h91, 8'h00);
        op(1, 0, 8'h92, r0);
        rd(8'h92, r0);
        op(1, 0, 8'h93, r1);
        op(1, 0, 8'h94, 8'hfd);
        op(1, 0, 8'h95, 8'hff);
        rd(8'h94, 8'hfd);
        v = {r1, r0};
        op(1, 0, 8'h91, 8'h04);
        idle(3);
        rd(8'h91, 8'h84, 8'hbf);
        rd(8'h94, 8'(v + 16'h1));
        rd(8'h95, 8'((v + 16'h2) >> 8));
        check("irq", 8'(irq), 8'h01);
        op(1, 0, 8'h94, 8'hfe);
        op(1, 0, 8'h95, 8'h00);
        op(1, 0, 8'h91, 8'h24);
        idle(2);
        rd(8'h91, 8'h64);
        check("irq", 8'(irq), 8'h01);
        op(1, 0, 8'h94, 8'hfe);
        op(1, 0, 8'h95, 8'hfe);
        op(1, 0, 8'h91, 8'h08);
        idle(1);
        check("irq", 8'(irq), 8'h00);
        idle(1);
        rd(8'h94, 8'h02);
        rd(8'h95, 8'hff);
        rd(8'h91, 8'h48);
        check("irq", 8'(irq), 8'h00);
        op(1, 0, 8'h91, 8'h68);
        idle(1);
        check("irq", 8'(irq), 8'h01);
        for (int k = 0; k < 2; k++) begin
            hsel = 0;
            tie = k[0] ? 1'b0 : 1'b1;
            op(1, 0, 8'h91, 8'h00);
            op(1, 0, 8'h94, 8'h00);
            op(1, 0, 8'h95, 8'h00);
            op(1, 0, 8'h91, k[0] ? 8'h05 : 8'h04);
            idle(240);
            rd(8'h94, k[0] ? 8'h08 : 8'h10, 8'hf8);
        end
        tie = 1;
        op(1, 0, 8'h91, 8'h00);
        op(1, 0, 8'h94, r1);
        op(1, 0, 8'h95, r0);
        op(1, 0, 8'h91, 8'h10);
        lfo_out = 1;
        idle(6);
        rd(8'h92, r1);
        rd(8'h93, r0);
        check("irq", 8'(irq), 8'h01);
        op(1, 0, 8'h91, 8'h00);
        idle(1);
        check("irq", 8'(irq), 8'h00);
        idle(2);
        stop_test();
    end
endmodule : test_split_autoreload_timer
